// >>> common/crc_pkg.sv
// Package of constants and types for the cyclic retransmit controller
package crc_pkg;
	localparam int SEQ_W = 7;
	localparam int UNIT_MAX = 127;
	localparam int LEN_W = 8;
	localparam int OCT_W = 16;
	localparam int PROP_DELAY_MS = 15;
	localparam logic [1:0] SND_FILL = 2'h0;
	localparam logic [1:0] SND_NEW = 2'h1;
	localparam logic [1:0] SND_CYC = 2'h2;
	localparam logic [1:0] SND_FRC = 2'h3;
	localparam logic [6:0] RST_UNIT_THR = 7'h4c;
	localparam logic [15:0] RST_OCT_THR = 16'h0ed8;
	typedef enum logic [0:0] {
		CRC_NORMAL = 1'b0,
		CRC_FORCED = 1'b1
	} crc_mode_t;
endpackage

// >>> hdl/crc_ctrl.sv
// Transmit-side cyclic retransmission controller
`timescale 1ns/100ps
module crc_ctrl (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [6:0] unit_thr,
	input wire logic [15:0] oct_thr,
	input wire logic new_valid,
	input wire logic [7:0] new_len,
	input wire logic [6:0] new_seq,
	output logic new_ready,
	input wire logic ack_valid,
	input wire logic [6:0] ack_seq,
	input wire logic nack_valid,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [1:0] tx_kind,
	output logic [6:0] tx_seq,
	output logic [7:0] tx_len,
	output logic forced,
	output logic [6:0] unit_cnt,
	output logic [15:0] oct_cnt
);
	// Ring of buffered unit lengths, indexed by sequence number
	logic [7:0] len_mem [0:127];
	logic [6:0] head_q, head_d, tail_q, tail_d, cur_q, cur_d;
	logic [6:0] cnt_q, cnt_d, ack_q, ack_d, pass_end_q, pass_end_d;
	logic [15:0] oct_q, oct_d;
	logic ack_pend_q, ack_pend_d;
	crc_pkg::crc_mode_t mode_q, mode_d;
	logic [1:0] kind_q, kind_d;
	logic [6:0] seq_q, seq_d;
	logic [7:0] olen_q, olen_d;
	logic thr_hit, take_new, do_free, pass_last;
	logic [6:0] lim_thr;

	// Unit threshold clipped to the sequence range
	assign lim_thr = (unit_thr > 7'(crc_pkg::UNIT_MAX)) ? 7'(crc_pkg::UNIT_MAX) : unit_thr;
	assign thr_hit = (cnt_q >= lim_thr) || (oct_q >= oct_thr);
	// Negative acknowledgments are deliberately unused
	logic unused_nack;
	assign unused_nack = nack_valid;
	assign new_ready = clk_en && tx_ready && mode_q == crc_pkg::CRC_NORMAL && !thr_hit
		&& cnt_q != 7'(crc_pkg::UNIT_MAX);
	assign take_new = new_ready && new_valid;
	assign pass_last = (cur_q == pass_end_q);
	// Frees are held during a forced pass and in a cycle that accepts a new unit, applied one per cycle otherwise
	assign do_free = ack_pend_q && cnt_q != 7'h00 && head_q != ack_q + 7'h01
		&& mode_q == crc_pkg::CRC_NORMAL && !take_new;

	// Next state for buffer, counters, mode and output unit
	always_comb begin
		head_d = head_q;
		tail_d = tail_q;
		cur_d = cur_q;
		cnt_d = cnt_q;
		oct_d = oct_q;
		ack_d = ack_q;
		ack_pend_d = ack_pend_q;
		mode_d = mode_q;
		pass_end_d = pass_end_q;
		kind_d = kind_q;
		seq_d = seq_q;
		olen_d = olen_q;
		if (ack_valid) begin
			ack_d = ack_seq;
			ack_pend_d = 1'b1;
		end
		if (tx_ready) begin
			unique case (mode_q)
				crc_pkg::CRC_NORMAL: begin
					// Held acks drain before thresholds are judged again
					if (thr_hit && cnt_q != 7'h00 && !do_free) begin
						// Enter a pass starting at the oldest unit
						mode_d = crc_pkg::CRC_FORCED;
						cur_d = head_q;
						pass_end_d = tail_q - 7'h01;
						kind_d = crc_pkg::SND_FILL;
					end else if (take_new) begin
						kind_d = crc_pkg::SND_NEW;
						seq_d = new_seq;
						olen_d = new_len;
						tail_d = new_seq + 7'h01;
						if (cnt_q == 7'h00) begin
							head_d = new_seq;
							cur_d = new_seq;
						end
						cnt_d = cnt_q + 7'h01;
						oct_d = oct_q + 16'(new_len);
					end else if (cnt_q != 7'h00) begin
						kind_d = crc_pkg::SND_CYC;
						seq_d = cur_q;
						olen_d = len_mem[cur_q];
						cur_d = (cur_q + 7'h01 == tail_q) ? head_q : cur_q + 7'h01;
					end else begin
						kind_d = crc_pkg::SND_FILL;
					end
				end
				crc_pkg::CRC_FORCED: begin
					kind_d = crc_pkg::SND_FRC;
					seq_d = cur_q;
					olen_d = len_mem[cur_q];
					cur_d = cur_q + 7'h01;
					if (pass_last) begin
						mode_d = crc_pkg::CRC_NORMAL;
						cur_d = head_q;
					end
				end
			endcase
		end
		if (do_free) begin
			head_d = head_q + 7'h01;
			cnt_d = cnt_q - 7'h01;
			oct_d = oct_q - 16'(len_mem[head_q]);
			if (cur_q == head_q)
				cur_d = head_q + 7'h01;
		end else if (ack_pend_q && mode_q == crc_pkg::CRC_NORMAL && !take_new) begin
			ack_pend_d = ack_valid;
		end
	end

	// Registers only; memory write on acceptance of a new unit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			head_q <= 7'h00;
			tail_q <= 7'h00;
			cur_q <= 7'h00;
			cnt_q <= 7'h00;
			oct_q <= 16'h0000;
			ack_q <= 7'h00;
			ack_pend_q <= 1'b0;
			mode_q <= crc_pkg::CRC_NORMAL;
			pass_end_q <= 7'h00;
			kind_q <= crc_pkg::SND_FILL;
			seq_q <= 7'h00;
			olen_q <= 8'h00;
		end else if (clk_en) begin
			head_q <= head_d;
			tail_q <= tail_d;
			cur_q <= cur_d;
			cnt_q <= cnt_d;
			oct_q <= oct_d;
			ack_q <= ack_d;
			ack_pend_q <= ack_pend_d;
			mode_q <= mode_d;
			pass_end_q <= pass_end_d;
			kind_q <= kind_d;
			seq_q <= seq_d;
			olen_q <= olen_d;
		end
	end

	always_ff @(posedge clk) begin
		if (clk_en && take_new)
			len_mem[new_seq] <= new_len;
	end

	assign tx_valid = rst_b;
	assign tx_kind = kind_q;
	assign tx_seq = seq_q;
	assign tx_len = olen_q;
	assign forced = (mode_q == crc_pkg::CRC_FORCED);
	assign unit_cnt = cnt_q;
	assign oct_cnt = oct_q;

	// Checks
	a_no_new_forced: assert property (@(posedge clk) disable iff (!rst_b)
		forced |-> !new_ready) else $error("new unit accepted while forced");
	a_thr_blocks: assert property (@(posedge clk) disable iff (!rst_b)
		thr_hit |-> !new_ready) else $error("new unit accepted at threshold");
	a_no_free_forced: assert property (@(posedge clk) disable iff (!rst_b)
		forced && clk_en |=> cnt_q >= $past(cnt_q)) else $error("unit freed mid pass");
	a_frc_order: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && tx_ready && forced && !pass_last |=> tx_seq + 7'h01 == cur_q)
		else $error("forced order broken");
	a_new_count: assert property (@(posedge clk) disable iff (!rst_b)
		take_new && !do_free |=> cnt_q == $past(cnt_q) + 7'h01) else $error("count missed");
	a_new_first: assert property (@(posedge clk) disable iff (!rst_b)
		take_new && tx_ready |=> tx_kind == crc_pkg::SND_NEW) else $error("new unit not sent");
	a_cyc_idle: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && tx_ready && !forced && !thr_hit && !new_valid && cnt_q != 7'h00
		|=> tx_kind == crc_pkg::SND_CYC) else $error("cyclic resend missing");
	a_fill_empty: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && tx_ready && !forced && !new_valid && cnt_q == 7'h00
		|=> tx_kind == crc_pkg::SND_FILL) else $error("fill unit missing");
	a_free_first: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && !forced && do_free |=> !forced) else $error("pass began before acks applied");
	a_cnt_cap: assert property (@(posedge clk) disable iff (!rst_b)
		cnt_q <= 7'(crc_pkg::UNIT_MAX)) else $error("count past range");
	c_forced: cover property (@(posedge clk) disable iff (!rst_b) $rose(forced));
	c_resume: cover property (@(posedge clk) disable iff (!rst_b) $fell(forced));
	c_free: cover property (@(posedge clk) disable iff (!rst_b) do_free);
endmodule

// >>> sim/crc_far_end.sv
// Far-end link terminal model that returns acknowledgments on request
`timescale 1ns/100ps
module crc_far_end (
	input wire logic clk,
	input wire logic ack_req,
	input wire logic [6:0] req_seq,
	input wire logic nack_req,
	output logic ack_valid,
	output logic [6:0] ack_seq,
	output logic nack_valid
);
	// One-cycle ack pulse; idle seq toggles so a stale value never looks valid
	always @(negedge clk) begin
		ack_valid <= ack_req;
		ack_seq <= ack_req ? req_seq : ~ack_seq;
		nack_valid <= nack_req;
	end
endmodule

// >>> sim/crc_ctrl_tb.sv
// Self-checking bench for the cyclic retransmit controller
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
`define WAIT(c, n) begin for (int k = 0; k < (n) && (c) !== 1'b1; k++) @(negedge clk); \
	if ((c) !== 1'b1) begin n_mismatch++; finish_test(); end end
module crc_ctrl_tb;
	logic clk, rst_b, new_valid, new_ready, ack_valid, nack_valid, tx_valid, forced;
	logic ack_req, nack_req, tx_ready;
	logic [6:0] unit_thr, new_seq, ack_seq, req_seq, tx_seq, unit_cnt, nxt;
	logic [7:0] new_len, tx_len;
	logic [15:0] oct_thr, oct_cnt;
	logic [1:0] tx_kind;
	int n_mismatch = 0;
	int n_compared = 0;
	crc_ctrl crc_ctrl_inst (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .unit_thr(unit_thr),
		.oct_thr(oct_thr), .new_valid(new_valid), .new_len(new_len), .new_seq(new_seq),
		.new_ready(new_ready), .ack_valid(ack_valid), .ack_seq(ack_seq),
		.nack_valid(nack_valid), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_kind(tx_kind),
		.tx_seq(tx_seq), .tx_len(tx_len), .forced(forced), .unit_cnt(unit_cnt),
		.oct_cnt(oct_cnt));
	crc_far_end crc_far_end_inst (.clk(clk), .ack_req(ack_req), .req_seq(req_seq),
		.nack_req(nack_req), .ack_valid(ack_valid), .ack_seq(ack_seq), .nack_valid(nack_valid));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic finish_test();
		if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Unit thresholds stay within the 127-unit sequence range
	task automatic do_reset(input logic [6:0] ut, input logic [15:0] ot);
		@(negedge clk);
		rst_b = 1'b0;
		unit_thr = ut;
		oct_thr = ot;
		nxt = 7'h00;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
	endtask
	task automatic send(input int n, input logic [7:0] len);
		for (int i = 0; i < n; i++) begin
			new_valid = 1'b1;
			new_seq = nxt;
			new_len = len;
			`CHK("new_ready", 1'b1, new_ready)
			@(negedge clk);
			nxt++;
		end
		new_valid = 1'b0;
	endtask
	// Walks one forced pass; optional ack of units 0..1 lands mid-pass
	task automatic pass(input logic do_ack);
		int i;
		i = 0;
		for (int k = 0; k < 20; k++) begin
			if (tx_kind === crc_pkg::SND_FRC) begin
				`CHK("frc_seq", i[6:0], tx_seq)
				`CHK("frc_cnt", 7'h03, unit_cnt)
				`CHK("frc_rdy", 1'b0, new_ready)
				`CHK("frc_len", 8'h05, tx_len)
				i++;
				if (i == 3) break;
			end else if (forced !== 1'b1) break;
			ack_req <= do_ack && i == 1;
			req_seq <= 7'h01;
			@(negedge clk);
		end
		`CHK("frc_units", 3, i)
	endtask
	// Main sequence; inputs change on falling edges only
	initial begin
		{rst_b, new_valid, ack_req, nack_req} = 4'h0;
		{new_seq, new_len, req_seq} = '0;
		tx_ready = 1'b1;
		do_reset(7'h7f, 16'hffff);
		`CHK("idle_kind", crc_pkg::SND_FILL, tx_kind)
		`CHK("tx_valid", 1'b1, tx_valid)
		send(3, 8'h0a);
		`CHK("new_kind", crc_pkg::SND_NEW, tx_kind)
		`CHK("cnt", 7'h03, unit_cnt)
		`CHK("oct", 16'h001e, oct_cnt)
		nack_req <= 1'b1;
		@(negedge clk);
		nack_req <= 1'b0;
		repeat (4) @(negedge clk);
		`CHK("cyc_kind", crc_pkg::SND_CYC, tx_kind)
		`CHK("nack_cnt", 7'h03, unit_cnt)
		send(1, 8'h0a);
		`CHK("int_kind", crc_pkg::SND_NEW, tx_kind)
		ack_req <= 1'b1;
		req_seq <= 7'h01;
		@(negedge clk);
		ack_req <= 1'b0;
		`WAIT(unit_cnt == 7'h02, 10)
		`CHK("ack_oct", 16'h0014, oct_cnt)
		do_reset(7'h03, 16'hffff);
		send(3, 8'h05);
		`WAIT(forced, 4)
		pass(1'b0);
		`WAIT(forced, 6)
		pass(1'b1);
		`WAIT(unit_cnt == 7'h01, 20)
		`CHK("resume", 1'b0, forced)
		do_reset(7'h7f, 16'h0014);
		send(2, 8'h0a);
		`WAIT(forced, 4)
		`CHK("oct_thr", 16'h0014, oct_cnt)
		finish_test();
	end
endmodule
